//--- pdm_map.svh
// Register map, field positions, reset values and timing constants
`ifndef PDM_MAP_SVH
`define PDM_MAP_SVH

// Register offsets
`define PDM_ADDR_W 12
`define PDM_OFF_PS_CONFIG 12'h1f0
`define PDM_OFF_PS_STATE 12'h1f1
`define PDM_OFF_WATCHDOG 12'h1f4
`define PDM_OFF_INT_STATUS 12'h1f8
`define PDM_OFF_INT_MASK 12'h1f9
`define PDM_OFF_DISP_SELECT 12'h1fc

// Field positions
`define PDM_PS_EN_BIT 0
`define PDM_PS_RSVD_BIT 4
`define PDM_ST_MEM_BIT 0
`define PDM_ST_PANEL_BIT 1
`define PDM_WD_MSB 5
`define PDM_DISP_MODE_MSB 2
`define PDM_DISP_ROT_BIT 6

// Interrupt status bits
`define PDM_INT_W 4
`define PDM_INT_WATCHDOG 0
`define PDM_INT_PANEL_UP 1
`define PDM_INT_PANEL_DOWN 2
`define PDM_INT_MEM_SLEEP 3

// Reset values
`define PDM_RST_PS_CONFIG 8'h00
`define PDM_RST_WATCHDOG 6'h00
`define PDM_RST_DISP_SELECT 8'h00
`define PDM_RST_INT_MASK 4'h0

// Timing
`define PDM_CLK_PERIOD_PS 5000
`define PDM_WD_BUS_MUL 8
`define PDM_WD_BUS_ADD 7
`define PDM_WD_MEM_PERIODS 13
`define PDM_PANEL_SEQ_US 100
`define PDM_PANEL_SEQ_CYCLES ((`PDM_PANEL_SEQ_US * 1000000) / \
    `PDM_CLK_PERIOD_PS)

`endif

//--- pdm_pkg.sv
// Types shared by the power, display and misc control block
package pdm_pkg;

    // Panel power sequencer, Gray coded along off-up-on-down
    typedef enum logic [1:0] {
        PDM_PANEL_OFF = 2'b00,
        PDM_PANEL_UP = 2'b01,
        PDM_PANEL_ON = 2'b11,
        PDM_PANEL_DOWN = 2'b10
    } pdm_panel_state_type;

    // Output enables decoded from the display mode select field
    typedef struct packed {
        logic panel;
        logic crt;
        logic tv;
        logic flicker_filter;
        logic dual_independent_display;
    } pdm_disp_out_type;

    // One RGB pixel of the TV path
    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } pdm_pixel_type;

endpackage

//--- pdm_top.sv
// Power save, memory watchdog and display mode control register bank
`timescale 1ns/1ps
`include "pdm_map.svh"

module pdm_top #(
    parameter int unsigned BUS_CLK_PERIOD_PS = 30000,
    parameter int unsigned MEM_CLK_PERIOD_PS = 15000,
    parameter int unsigned PANEL_SEQ_CYCLES = `PDM_PANEL_SEQ_CYCLES,
    parameter int unsigned LINE_PIXELS = 720,
    parameter int unsigned WD_CNT_W = 16
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [`PDM_ADDR_W-1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // Straps and status from other clock domains
    input wire logic bus_clock_divide_strap_i,
    input wire logic mem_ctrl_asleep_i,
    // CPU-to-memory cycle tracking
    input wire logic cpu_mem_cycle_i,
    output logic cpu_mem_cycle_end_o,
    // Power control
    output logic mem_power_save_req_o,
    output logic panel_power_o,
    output logic panel_signals_o,
    // Display control
    input wire logic rotate_bit1_i,
    output pdm_pkg::pdm_disp_out_type disp_out_o,
    output logic [1:0] rotation_o,
    // TV pixel path
    input wire logic tv_line_start_i,
    input wire logic tv_pix_valid_i,
    input wire pdm_pkg::pdm_pixel_type tv_pix_i,
    output logic tv_pix_valid_o,
    output pdm_pkg::pdm_pixel_type tv_pix_o,
    // Interrupt
    output logic irq_o
);

    localparam int unsigned COL_W = $clog2(LINE_PIXELS);
    localparam int unsigned PSEQ_W = $clog2(PANEL_SEQ_CYCLES + 1);

    // Refuse settings the counters cannot hold
    if (LINE_PIXELS < 2 || PANEL_SEQ_CYCLES < 1 || WD_CNT_W < 8 ||
        WD_CNT_W > 31) begin : g_bad_param
        $error("pdm_top: unsupported parameter value");
    end

    // Watchdog limit in ref_clk cycles, rounded down, never below one
    function automatic logic [WD_CNT_W-1:0] wd_limit(
        input logic [5:0] n,
        input logic slow_bus
    );
        longint unsigned bus_ps;
        longint unsigned total_ps;
        longint unsigned cycles;
        bus_ps = slow_bus ? 2 * BUS_CLK_PERIOD_PS : BUS_CLK_PERIOD_PS;
        total_ps = (`PDM_WD_BUS_MUL * n + `PDM_WD_BUS_ADD) * bus_ps +
            `PDM_WD_MEM_PERIODS * MEM_CLK_PERIOD_PS;
        cycles = total_ps / `PDM_CLK_PERIOD_PS;
        if (cycles < 1) begin
            cycles = 1;
        end
        if (cycles >= (64'd1 << WD_CNT_W)) begin
            cycles = (64'd1 << WD_CNT_W) - 1;
        end
        return cycles[WD_CNT_W-1:0];
    endfunction

    // Rounded mean of two colour channels
    function automatic logic [7:0] avg8(
        input logic [7:0] a,
        input logic [7:0] b
    );
        logic [8:0] sum;
        sum = {1'b0, a} + {1'b0, b} + 9'h001;
        return sum[8:1];
    endfunction

    // Registers
    logic ps_en_r;
    logic [5:0] wd_n_r;
    logic [7:0] disp_sel_r;
    logic [`PDM_INT_W-1:0] int_status_r;
    logic [`PDM_INT_W-1:0] int_mask_r;
    logic [`PDM_INT_W-1:0] int_event;
    logic wr_config;
    logic wr_watchdog;
    logic wr_disp;
    logic wr_int_status;
    logic wr_int_mask;

    assign wr_config = reg_wr_i && reg_addr_i == `PDM_OFF_PS_CONFIG;
    assign wr_watchdog = reg_wr_i && reg_addr_i == `PDM_OFF_WATCHDOG;
    assign wr_disp = reg_wr_i && reg_addr_i == `PDM_OFF_DISP_SELECT;
    assign wr_int_status = reg_wr_i && reg_addr_i == `PDM_OFF_INT_STATUS;
    assign wr_int_mask = reg_wr_i && reg_addr_i == `PDM_OFF_INT_MASK;

    // Software writable control; unused bits are simply not stored
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            ps_en_r <= 1'(`PDM_RST_PS_CONFIG >> `PDM_PS_EN_BIT);
            wd_n_r <= `PDM_RST_WATCHDOG;
            disp_sel_r <= `PDM_RST_DISP_SELECT;
            int_mask_r <= `PDM_RST_INT_MASK;
        end else begin
            if (wr_config) begin
                ps_en_r <= reg_wdata_i[`PDM_PS_EN_BIT];
            end
            if (wr_watchdog) begin
                wd_n_r <= reg_wdata_i[`PDM_WD_MSB:0];
            end
            if (wr_disp) begin
                disp_sel_r <= reg_wdata_i & 8'h47;
            end
            if (wr_int_mask) begin
                int_mask_r <= reg_wdata_i[`PDM_INT_W-1:0];
            end
        end
    end

    // Pin-side inputs pass two flops first; no reset, so the strap has
    // already settled in the chain when reset lifts and is caught
    logic [1:0] strap_sync_r;
    logic [1:0] mem_sleep_sync_r;
    always_ff @(posedge ref_clk_i) begin
        strap_sync_r <= {strap_sync_r[0], bus_clock_divide_strap_i};
        mem_sleep_sync_r <= {mem_sleep_sync_r[0], mem_ctrl_asleep_i};
    end

    // Strap caught once after reset release, then held
    logic strap_r;
    logic strap_taken_r;
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            strap_r <= 1'b0;
            strap_taken_r <= 1'b0;
        end else if (!strap_taken_r) begin
            strap_r <= strap_sync_r[1];
            strap_taken_r <= 1'b1;
        end
    end

    // Memory sleep status and the power save request
    logic mem_asleep_r;
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            mem_asleep_r <= 1'b0;
            mem_power_save_req_o <= 1'b0;
        end else begin
            mem_asleep_r <= mem_sleep_sync_r[1];
            mem_power_save_req_o <= ps_en_r;
        end
    end

    // Panel power sequencer; power save forces the panel down
    pdm_pkg::pdm_panel_state_type panel_state_r;
    pdm_pkg::pdm_panel_state_type panel_state_nxt;
    logic [PSEQ_W-1:0] pseq_cnt_r;
    logic panel_want;
    logic pseq_done;

    assign panel_want = disp_sel_r[0] && !ps_en_r;
    assign pseq_done = pseq_cnt_r == PSEQ_W'(PANEL_SEQ_CYCLES - 1);

    // A reversal mid-sequence waits for the current step to end
    always_comb begin
        panel_state_nxt = panel_state_r;
        unique case (panel_state_r)
            pdm_pkg::PDM_PANEL_OFF: begin
                if (panel_want) begin
                    panel_state_nxt = pdm_pkg::PDM_PANEL_UP;
                end
            end
            pdm_pkg::PDM_PANEL_UP: begin
                if (pseq_done) begin
                    panel_state_nxt = pdm_pkg::PDM_PANEL_ON;
                end
            end
            pdm_pkg::PDM_PANEL_ON: begin
                if (!panel_want) begin
                    panel_state_nxt = pdm_pkg::PDM_PANEL_DOWN;
                end
            end
            pdm_pkg::PDM_PANEL_DOWN: begin
                if (pseq_done) begin
                    panel_state_nxt = pdm_pkg::PDM_PANEL_OFF;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            panel_state_r <= pdm_pkg::PDM_PANEL_OFF;
            pseq_cnt_r <= '0;
        end else begin
            panel_state_r <= panel_state_nxt;
            if (panel_state_nxt != panel_state_r) begin
                pseq_cnt_r <= '0;
            end else if (!pseq_done) begin
                pseq_cnt_r <= pseq_cnt_r + PSEQ_W'(1);
            end
        end
    end

    // Panel outputs follow the next state so they match the status bit
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            panel_power_o <= 1'b0;
            panel_signals_o <= 1'b0;
        end else begin
            panel_power_o <= panel_state_nxt != pdm_pkg::PDM_PANEL_OFF;
            panel_signals_o <= panel_state_nxt == pdm_pkg::PDM_PANEL_ON;
        end
    end

    // Watchdog; other cycle kinds never raise cpu_mem_cycle_i
    logic [WD_CNT_W-1:0] wd_limit_r;
    logic [WD_CNT_W-1:0] wd_cnt_r;
    logic wd_fire;

    assign wd_fire = cpu_mem_cycle_i && wd_n_r != 6'h00 &&
        !cpu_mem_cycle_end_o && wd_cnt_r >= wd_limit_r - WD_CNT_W'(1);

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            wd_limit_r <= '0;
            wd_cnt_r <= '0;
            cpu_mem_cycle_end_o <= 1'b0;
        end else begin
            wd_limit_r <= wd_limit(wd_n_r, strap_r);
            cpu_mem_cycle_end_o <= wd_fire;
            if (!cpu_mem_cycle_i) begin
                wd_cnt_r <= '0;
            end else if (wd_cnt_r != '1) begin
                wd_cnt_r <= wd_cnt_r + WD_CNT_W'(1);
            end
        end
    end

    // Mode decode and rotation, registered for clean outputs
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            disp_out_o <= '0;
            rotation_o <= 2'h0;
        end else begin
            disp_out_o.panel <= disp_sel_r[0];
            disp_out_o.crt <= disp_sel_r[2:1] == 2'h1;
            disp_out_o.tv <= disp_sel_r[2];
            disp_out_o.flicker_filter <= disp_sel_r[2:1] == 2'h3;
            disp_out_o.dual_independent_display <=
                disp_sel_r[0] && disp_sel_r[2:1] != 2'h0;
            // Angle code counts quarter turns clockwise
            rotation_o <= {rotate_bit1_i,
                disp_sel_r[`PDM_DISP_ROT_BIT]};
        end
    end

    // Flicker filter: one line of memory holds the previous TV line
    pdm_pkg::pdm_pixel_type line_mem [LINE_PIXELS];
    pdm_pkg::pdm_pixel_type above_pix;
    logic [COL_W-1:0] col_r;
    logic filter_on;

    assign filter_on = disp_sel_r[2:1] == 2'h3;
    assign above_pix = line_mem[col_r];

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            col_r <= '0;
        end else if (tv_line_start_i) begin
            col_r <= '0;
        end else if (tv_pix_valid_i &&
            col_r != COL_W'(LINE_PIXELS - 1)) begin
            col_r <= col_r + COL_W'(1);
        end
    end

    // Line memory has no reset; the first filtered line mixes stale data
    always_ff @(posedge ref_clk_i) begin
        if (tv_pix_valid_i && !tv_line_start_i) begin
            line_mem[col_r] <= tv_pix_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            tv_pix_valid_o <= 1'b0;
            tv_pix_o <= '0;
        end else begin
            tv_pix_valid_o <= tv_pix_valid_i && !tv_line_start_i;
            if (filter_on) begin
                tv_pix_o.red <= avg8(tv_pix_i.red, above_pix.red);
                tv_pix_o.green <= avg8(tv_pix_i.green, above_pix.green);
                tv_pix_o.blue <= avg8(tv_pix_i.blue, above_pix.blue);
            end else begin
                tv_pix_o <= tv_pix_i;
            end
        end
    end

    // Events: watchdog fire, panel up done, panel down done, memory sleep
    logic mem_asleep_d_r;
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            mem_asleep_d_r <= 1'b0;
        end else begin
            mem_asleep_d_r <= mem_asleep_r;
        end
    end

    always_comb begin
        int_event = '0;
        int_event[`PDM_INT_WATCHDOG] = wd_fire;
        int_event[`PDM_INT_PANEL_UP] =
            panel_state_r == pdm_pkg::PDM_PANEL_UP && pseq_done;
        int_event[`PDM_INT_PANEL_DOWN] =
            panel_state_r == pdm_pkg::PDM_PANEL_DOWN && pseq_done;
        int_event[`PDM_INT_MEM_SLEEP] = mem_asleep_r && !mem_asleep_d_r;
    end

    // Sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            int_status_r <= '0;
            irq_o <= 1'b0;
        end else begin
            int_status_r <= (int_status_r &
                ~(wr_int_status ? reg_wdata_i[`PDM_INT_W-1:0] : '0)) |
                int_event;
            irq_o <= |(int_status_r & int_mask_r);
        end
    end

    // Read data one cycle after the strobe, zero elsewhere
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                `PDM_OFF_PS_CONFIG: reg_rdata_o <= {7'h00, ps_en_r};
                `PDM_OFF_PS_STATE: reg_rdata_o <= {6'h00,
                    panel_state_r == pdm_pkg::PDM_PANEL_OFF,
                    mem_asleep_r};
                `PDM_OFF_WATCHDOG: reg_rdata_o <= {2'h0, wd_n_r};
                `PDM_OFF_INT_STATUS: reg_rdata_o <= {4'h0, int_status_r};
                `PDM_OFF_INT_MASK: reg_rdata_o <= {4'h0, int_mask_r};
                `PDM_OFF_DISP_SELECT: reg_rdata_o <= disp_sel_r;
                default: reg_rdata_o <= 8'h00;
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

endmodule // pdm_top

//--- pdm_top_properties.sv
// Port checker for the power, display and misc control bank
`timescale 1ns/1ps
`include "pdm_map.svh"

module pdm_checker #(
    parameter int unsigned PANEL_SEQ_CYCLES = 4
) (
    // Clock, reset and register port
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [`PDM_ADDR_W-1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    // Watched side signals
    input wire logic mem_ctrl_asleep_i,
    input wire logic cpu_mem_cycle_i,
    input wire logic cpu_mem_cycle_end_o,
    input wire logic mem_power_save_req_o,
    input wire logic panel_power_o,
    input wire logic panel_signals_o,
    input wire logic rotate_bit1_i,
    input wire pdm_pkg::pdm_disp_out_type disp_out_o,
    input wire logic [1:0] rotation_o
);
    // A reversal mid-step may cost two full steps
    localparam int SEQ_MAX = 2 * PANEL_SEQ_CYCLES + 4;
    logic [5:0] wd_n_r;
    logic [7:0] w1_r;
    logic [7:0] w2_r;
    logic rd_st;
    logic wr_sel;
    logic wr_cfg;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    // Decoded strobes
    assign rd_st = reg_rd_i && reg_addr_i == `PDM_OFF_PS_STATE;
    assign wr_sel = reg_wr_i && reg_addr_i == `PDM_OFF_DISP_SELECT;
    assign wr_cfg = reg_wr_i && reg_addr_i == `PDM_OFF_PS_CONFIG;

    // Shadow of the watchdog count and a write data delay line
    always_ff @(posedge ref_clk_i) begin
        w1_r <= reg_wdata_i;
        w2_r <= w1_r;
        if (!rst_n_i) begin
            wd_n_r <= 6'h00;
        end else if (reg_wr_i && reg_addr_i == `PDM_OFF_WATCHDOG) begin
            wd_n_r <= reg_wdata_i[5:0];
        end
    end

    rdata_idle_a: assert property (!$past(reg_rd_i) |-> !reg_rdata_o)
        else $error("read data not zero outside read slot");
    cfg_unused_a: assert property ($past(reg_rd_i &&
        reg_addr_i == `PDM_OFF_PS_CONFIG) |-> reg_rdata_o[7:1] == 7'h00)
        else $error("unused config bits read nonzero");
    panel_state_a: assert property ($past(rd_st) |->
        reg_rdata_o[7:2] == 6'h00 && reg_rdata_o[1] == !$past(panel_power_o))
        else $error("panel status bit wrong");
    mem_asleep_a: assert property (mem_ctrl_asleep_i[*5] ##0 rd_st
        |=> reg_rdata_o[0]) else $error("memory sleep status not set");
    mem_awake_a: assert property ((!mem_ctrl_asleep_i)[*5] ##0 rd_st
        |=> !reg_rdata_o[0]) else $error("memory sleep status set");
    disp_decode_a: assert property (wr_sel ##1 !wr_sel |=>
        disp_out_o == {w2_r[0], w2_r[1] & !w2_r[2], w2_r[2],
        w2_r[2] & w2_r[1], w2_r[0] & (w2_r[1] | w2_r[2])} &&
        rotation_o[0] == w2_r[6]) else $error("display outputs wrong");
    rot_follow_a: assert property ($past(rst_n_i) |->
        rotation_o[1] == $past(rotate_bit1_i))
        else $error("second rotation bit not followed");
    ps_req_a: assert property (wr_cfg ##1 !wr_cfg |=>
        mem_power_save_req_o == w2_r[0]) else $error("power save request");
    panel_on_a: assert property ($rose(panel_power_o) |->
        ##[1:SEQ_MAX] (panel_signals_o || !panel_power_o))
        else $error("panel power-on never completed");
    signals_pow_a: assert property (panel_signals_o |-> panel_power_o)
        else $error("panel signals without panel power");
    panel_off_a: assert property ($fell(panel_signals_o) |->
        ##[1:SEQ_MAX] !panel_power_o) else $error("panel power-off stuck");
    wd_off_a: assert property (wd_n_r == 6'h00 && $past(wd_n_r) == 6'h00
        && $past(wd_n_r, 2) == 6'h00 |-> !cpu_mem_cycle_end_o)
        else $error("watchdog fired while disabled");
    wd_early_a: assert property ($rose(cpu_mem_cycle_i) |->
        (!cpu_mem_cycle_end_o)[*8]) else $error("watchdog fired early");
    wd_in_cycle_a: assert property (cpu_mem_cycle_end_o |->
        $past(cpu_mem_cycle_i)) else $error("watchdog outside cycle");
endmodule // pdm_checker

bind pdm_top pdm_checker #(.PANEL_SEQ_CYCLES(PANEL_SEQ_CYCLES)) u_chk (
    .ref_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .mem_ctrl_asleep_i, .cpu_mem_cycle_i, .cpu_mem_cycle_end_o,
    .mem_power_save_req_o, .panel_power_o, .panel_signals_o, .rotate_bit1_i,
    .disp_out_o, .rotation_o);

//--- power_display_misc_control_tb_top.sv
// Self-checking bench for the power, display and misc control bank
`timescale 1ns/1ps
`include "pdm_map.svh"

module power_display_misc_control_tb_top;
    localparam int SEQ = 8;
    localparam int LPIX = 4;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [`PDM_ADDR_W-1:0] reg_addr_i = '0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic bus_clock_divide_strap_i = 1'b0;
    logic mem_ctrl_asleep_i = 1'b0;
    logic cpu_mem_cycle_i = 1'b0;
    logic rotate_bit1_i = 1'b0;
    logic tv_line_start_i = 1'b0;
    logic tv_pix_valid_i = 1'b0;
    pdm_pkg::pdm_pixel_type tv_pix_i = '0;
    logic [7:0] reg_rdata_o;
    logic cpu_mem_cycle_end_o, mem_power_save_req_o, irq_o;
    logic panel_power_o, panel_signals_o, tv_pix_valid_o;
    logic [1:0] rotation_o;
    pdm_pkg::pdm_disp_out_type disp_out_o;
    pdm_pkg::pdm_pixel_type tv_pix_o;
    pdm_pkg::pdm_pixel_type prv [LPIX];
    int err_count = 0;
    int tests_run = 0;
    int k;
    logic [31:0] seed = 32'h48;
    logic [31:0] r;
    logic [7:0] rd_v, m_cfg, m_wd, m_sel;

    // Free-running 200 MHz clock
    always #2.5 ref_clk_i = ~ref_clk_i;

    pdm_top #(.PANEL_SEQ_CYCLES(SEQ), .LINE_PIXELS(LPIX)) DUT (
        .ref_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
        .reg_rd_i, .reg_rdata_o, .bus_clock_divide_strap_i,
        .mem_ctrl_asleep_i, .cpu_mem_cycle_i, .cpu_mem_cycle_end_o,
        .mem_power_save_req_o, .panel_power_o, .panel_signals_o,
        .rotate_bit1_i, .disp_out_o, .rotation_o, .tv_line_start_i,
        .tv_pix_valid_i, .tv_pix_i, .tv_pix_valid_o, .tv_pix_o, .irq_o);

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Reference decode of the mode field
    function automatic logic [4:0] dec(input logic [7:0] m);
        return {m[0], m[1] & !m[2], m[2], m[2] & m[1], m[0] & (m[1] | m[2])};
    endfunction

    // Limit in fast-clock cycles for count n
    function automatic int wd_lim(input int n, input logic s);
        return ((8 * n + 7) * 30000 * (s ? 2 : 1) + 13 * 15000) / 5000;
    endfunction

    function automatic logic [7:0] avg(input logic [7:0] a, input logic [7:0] b);
        return 8'((int'(a) + int'(b) + 1) / 2);
    endfunction

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rchk(input logic [11:0] a, input logic [7:0] e);
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1 rd_v = reg_rdata_o;
        chk({16'h0, rd_v}, {16'h0, e});
    endtask

    task automatic wait_panel(input logic pw, input logic sg);
        #1;
        for (int i = 0; i < 60 && (panel_power_o !== pw ||
                panel_signals_o !== sg); i++) cyc(1);
        chk({22'h0, panel_power_o, panel_signals_o}, {22'h0, pw, sg});
    endtask

    // Open a memory cycle and count edges up to the forced end
    task automatic wd_run(input int n);
        wr(`PDM_OFF_WATCHDOG, 8'(n));
        @(posedge ref_clk_i);
        cpu_mem_cycle_i <= 1'b1;
        k = 0;
        while (cpu_mem_cycle_end_o !== 1'b1 && k < 600) begin
            cyc(1);
            k++;
        end
        @(posedge ref_clk_i);
        cpu_mem_cycle_i <= 1'b0;
        chk(24'(k), 24'(wd_lim(n, bus_clock_divide_strap_i)));
    endtask

    task automatic tv_line(input logic filt, input logic check);
        pdm_pkg::pdm_pixel_type p;
        @(posedge ref_clk_i);
        tv_line_start_i <= 1'b1;
        @(posedge ref_clk_i);
        tv_line_start_i <= 1'b0;
        for (int i = 0; i < LPIX; i++) begin
            p = 24'(xs());
            tv_pix_valid_i <= 1'b1;
            tv_pix_i <= p;
            @(posedge ref_clk_i);
            tv_pix_valid_i <= 1'b0;
            #1 chk({23'h0, tv_pix_valid_o}, 24'h1);
            if (check) begin
                chk(tv_pix_o, filt ? {avg(p.red, prv[i].red),
                    avg(p.green, prv[i].green), avg(p.blue, prv[i].blue)} : p);
            end
            prv[i] = p;
            @(posedge ref_clk_i);
        end
    endtask

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Hang guard, well beyond the expected run
    initial begin
        #200000;
        err_count++;
        wrap_up();
    end

    initial begin
        repeat (16) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        // Reset values and an unmapped place
        rchk(`PDM_OFF_PS_CONFIG, 8'h00);
        rchk(`PDM_OFF_WATCHDOG, 8'h00);
        rchk(`PDM_OFF_DISP_SELECT, 8'h00);
        rchk(`PDM_OFF_PS_STATE, 8'h02);
        wr(12'h1f2, 8'hff);
        rchk(12'h1f2, 8'h00);
        // Random register traffic against the model
        for (int i = 0; i < 8; i++) begin
            r = xs();
            m_cfg = r[7:0] & 8'hef;
            m_wd = r[15:8];
            m_sel = r[23:16];
            rotate_bit1_i <= r[24];
            wr(`PDM_OFF_PS_CONFIG, m_cfg);
            wr(`PDM_OFF_WATCHDOG, m_wd);
            wr(`PDM_OFF_DISP_SELECT, m_sel);
            cyc(3);
            chk(24'(disp_out_o), 24'(dec(m_sel)));
            chk(24'(rotation_o), {22'h0, r[24], m_sel[6]});
            chk({23'h0, mem_power_save_req_o}, {23'h0, m_cfg[0]});
            rchk(`PDM_OFF_PS_CONFIG, m_cfg & 8'h01);
            rchk(`PDM_OFF_WATCHDOG, m_wd & 8'h3f);
            rchk(`PDM_OFF_DISP_SELECT, m_sel & 8'h47);
        end
        // Panel sequences by mode bit and by power save
        wr(`PDM_OFF_PS_CONFIG, 8'h00);
        wr(`PDM_OFF_DISP_SELECT, 8'h00);
        wait_panel(1'b0, 1'b0);
        wr(`PDM_OFF_INT_STATUS, 8'h0f);
        wr(`PDM_OFF_DISP_SELECT, 8'h01);
        rchk(`PDM_OFF_PS_STATE, 8'h00);
        wait_panel(1'b1, 1'b1);
        wr(`PDM_OFF_PS_CONFIG, 8'h01);
        wait_panel(1'b0, 1'b0);
        rchk(`PDM_OFF_PS_STATE, 8'h02);
        rchk(`PDM_OFF_INT_STATUS, 8'h06);
        wr(`PDM_OFF_PS_CONFIG, 8'h00);
        wait_panel(1'b1, 1'b1);
        wr(`PDM_OFF_DISP_SELECT, 8'h00);
        rchk(`PDM_OFF_PS_STATE, 8'h00);
        wait_panel(1'b0, 1'b0);
        // Memory sleep status and the interrupt path
        wr(`PDM_OFF_INT_STATUS, 8'h0f);
        mem_ctrl_asleep_i <= 1'b1;
        cyc(6);
        rchk(`PDM_OFF_PS_STATE, 8'h03);
        rchk(`PDM_OFF_INT_STATUS, 8'h08);
        chk({23'h0, irq_o}, 24'h0);
        wr(`PDM_OFF_INT_MASK, 8'h08);
        cyc(2);
        chk({23'h0, irq_o}, 24'h1);
        wr(`PDM_OFF_INT_STATUS, 8'h08);
        cyc(2);
        chk({23'h0, irq_o}, 24'h0);
        @(posedge ref_clk_i);
        mem_ctrl_asleep_i <= 1'b0;
        cyc(6);
        rchk(`PDM_OFF_PS_STATE, 8'h02);
        // Flicker filter on, then off
        wr(`PDM_OFF_DISP_SELECT, 8'h06);
        tv_line(1'b1, 1'b0);
        tv_line(1'b1, 1'b1);
        wr(`PDM_OFF_DISP_SELECT, 8'h04);
        tv_line(1'b0, 1'b1);
        // Watchdog limit, then disabled
        wd_run(1);
        rchk(`PDM_OFF_INT_STATUS, 8'h01);
        wr(`PDM_OFF_WATCHDOG, 8'h00);
        @(posedge ref_clk_i);
        cpu_mem_cycle_i <= 1'b1;
        k = 0;
        repeat (300) begin
            cyc(1);
            k += int'(cpu_mem_cycle_end_o !== 1'b0);
        end
        chk(24'(k), 24'h0);
        @(posedge ref_clk_i);
        cpu_mem_cycle_i <= 1'b0;
        // Second reset with the divide strap set
        rst_n_i <= 1'b0;
        bus_clock_divide_strap_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        wd_run(3);
        wrap_up();
    end
endmodule // power_display_misc_control_tb_top
